// ===== verilog/osc_ctrl_pkg.sv
// package: oscillator mode control constants, register map and carrier types
// Notes on behaviour
// - external clock modes use incoming clock at once, no start-up delay.
// - external clock output mode drives second pin with clock divided by four.
// - external clock io mode frees second pin as port A bit 6.
// - resistor-capacitor mode drives second pin with clock divided by four.
// - resistor-capacitor io mode frees second pin as port A bit 6.
// - fast crystal multiplier mode multiplies crystal up to 10 MHz by four.
// - crystal multiplier connected only for mode code 0110.
// - fast oscillator gives 8 MHz direct and postscaled 31 kHz to 4 MHz.
// - fast oscillator enabled when selected frequency is 125 kHz to 8 MHz.
// - slow oscillator enabled when selected or needed by listed features.
// - frequency select field picks fast direct, slow direct or postscaled fast.
// - first internal pin mode: clock/4 on second pin, first pin port A bit 7.
// - second internal pin mode: both pins are port A bits 7 and 6.
// - trim settles in 8 slow cycles or 1 ms; settling shown only in status bits 1 and 0.
// - multiplier enable is trim register bit 6, internal up to 32 MHz.
// - internal multiplier allowed only for mode codes 1001 or 1000.
// - internal multiplier works only with select 111 or 110.
// - where unavailable, multiplier enable reads zero and ignores writes.
// - at 31 kHz select, source select bit picks the internal oscillator.
// - source bit 1 divides 8 MHz by 256; bit 0 uses slow oscillator.
// - trim field is 5-bit two's complement, 0 is centre frequency.
// - select code 000 gives the 31 kHz output.
package osc_ctrl_pkg;
	// wishbone word offsets (byte addresses)
	localparam logic [3:0] ctrl_addr = 4'h0;
	localparam logic [3:0] trim_addr = 4'h4;
	localparam logic [3:0] feat_addr = 4'h8;
	localparam logic [3:0] status_addr = 4'hc;
	// trim register fields
	localparam int trim_src_bit = 7;
	localparam int trim_mul_bit = 6;
	localparam int trim_val_lsb = 0;
	localparam int trim_val_w = 5;
	localparam logic [7:0] trim_reset = 8'h00;
	// control register fields
	localparam int ctrl_freq_lsb = 4;
	localparam logic [7:0] ctrl_reset = 8'h00;
	// feature register bits
	localparam int feat_pwrt_bit = 0;
	localparam int feat_fscm_bit = 1;
	localparam int feat_wdt_bit = 2;
	localparam int feat_twosp_bit = 3;
	localparam int feat_lcd_slow_bit = 4;
	localparam logic [7:0] feat_reset = 8'h00;
	// oscillator mode configuration codes
	localparam logic [3:0] mode_lp = 4'h0;
	localparam logic [3:0] mode_xt = 4'h1;
	localparam logic [3:0] mode_hs = 4'h2;
	localparam logic [3:0] mode_ext_out = 4'h4;
	localparam logic [3:0] mode_ext_io = 4'h5;
	localparam logic [3:0] mode_hs_x4 = 4'h6;
	localparam logic [3:0] mode_rc_io = 4'h7;
	localparam logic [3:0] mode_int_two_io = 4'h8;
	localparam logic [3:0] mode_int_clkout = 4'h9;
	localparam logic [3:0] mode_rc_out = 4'hc;
	// frequency select codes
	localparam logic [2:0] freq_31k = 3'h0;
	localparam logic [2:0] freq_125k = 3'h1;
	localparam logic [2:0] freq_4m = 3'h6;
	localparam logic [2:0] freq_8m = 3'h7;
	localparam int mul_factor = 4;
	localparam int hs_x4_max_in_khz = 10000;
	localparam int int_x4_max_khz = 32000;
	localparam int fast_div_low = 256;
	// trim settle figures
	localparam int slow_settle_cycles = 8;
	localparam int fast_settle_ms = 1;
	localparam int clk_hz = 20000000;
	localparam int fast_settle_clks = fast_settle_ms * (clk_hz / 1000);
	localparam int settle_cnt_w = 15;
	localparam int clkout_div_w = 2;

	typedef enum logic [1:0] {src_primary, src_fast, src_slow, src_fast_div} clk_src_t;

	typedef struct packed {
		logic fast_osc_en;
		logic slow_osc_en;
		logic hs_mul_en;
		logic int_mul_en;
		logic fast_div256;
		logic start_delay_skip;
		clk_src_t src;
		logic [4:0] trim;
	} osc_cmd_t;

	typedef struct packed {
		logic out_o;
		logic out_oe;
		logic in_i;
	} pin_t;
endpackage

// ===== verilog/osc_ctrl.sv
// osc_ctrl: oscillator mode decode, internal oscillator control, trim register and pin muxing
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
module osc_ctrl #(
	parameter int fast_settle_clks = osc_ctrl_pkg::fast_settle_clks
)(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [3:0] osc_mode_config,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic slow_osc_tick,
	input wire logic clock_in_pin_i,
	output logic clock_in_pin_o,
	output logic clock_in_pin_oe,
	input wire logic clock_out_pin_i,
	output logic clock_out_pin_o,
	output logic clock_out_pin_oe,
	input wire logic gpio_a_bit6_o,
	input wire logic gpio_a_bit6_oe,
	output logic gpio_a_bit6_i,
	input wire logic gpio_a_bit7_o,
	input wire logic gpio_a_bit7_oe,
	output logic gpio_a_bit7_i,
	output osc_ctrl_pkg::osc_cmd_t osc_cmd
);
	logic [7:0] osc_control_register_q;
	logic [7:0] osc_trim_register_q;
	logic [7:0] feat_q;
	logic [1:0] div_q;
	logic [14:0] fast_cnt_q;
	logic [3:0] slow_cnt_q;
	logic [4:0] trim_prev_q;
	logic mul_avail;
	logic mode_ext;
	logic mode_rc;
	logic mode_int;
	logic [2:0] internal_freq_select;
	logic low_freq_source_select;
	logic multiplier_enable_eff;
	logic fast_settling;
	logic slow_settling;
	logic bus_req;
	logic wr_ctrl;
	logic wr_trim;
	logic wr_feat;
	logic out_div4;
	logic [31:0] rd_d;

	// mode decode
	assign mode_ext = (osc_mode_config == osc_ctrl_pkg::mode_ext_out) ||
		(osc_mode_config == osc_ctrl_pkg::mode_ext_io);
	assign mode_rc = (osc_mode_config == osc_ctrl_pkg::mode_rc_out) ||
		(osc_mode_config == osc_ctrl_pkg::mode_rc_io);
	assign mode_int = (osc_mode_config == osc_ctrl_pkg::mode_int_clkout) ||
		(osc_mode_config == osc_ctrl_pkg::mode_int_two_io);
	assign mul_avail = mode_int;
	assign internal_freq_select = osc_control_register_q[osc_ctrl_pkg::ctrl_freq_lsb +: 3];
	assign low_freq_source_select = osc_trim_register_q[osc_ctrl_pkg::trim_src_bit];

	// multiplier needs both the mode and a 4 or 8 MHz select
	assign multiplier_enable_eff = osc_trim_register_q[osc_ctrl_pkg::trim_mul_bit] && mul_avail &&
		((internal_freq_select == osc_ctrl_pkg::freq_8m) ||
		(internal_freq_select == osc_ctrl_pkg::freq_4m));

	// wishbone slave, single-cycle ack
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_ctrl = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == osc_ctrl_pkg::ctrl_addr);
	assign wr_trim = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == osc_ctrl_pkg::trim_addr);
	assign wr_feat = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == osc_ctrl_pkg::feat_addr);

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= bus_req;

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			osc_control_register_q <= osc_ctrl_pkg::ctrl_reset;
		else if (wr_ctrl)
			osc_control_register_q <= {1'b0, wb_dat_i[6:4], 4'h0};

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			feat_q <= osc_ctrl_pkg::feat_reset;
		else if (wr_feat)
			feat_q <= {3'h0, wb_dat_i[4:0]};

	// trim register: bit 5 reads zero, multiplier bit forced low where unavailable
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			osc_trim_register_q <= osc_ctrl_pkg::trim_reset;
		else if (wr_trim)
		begin
			osc_trim_register_q <= {wb_dat_i[7], wb_dat_i[6] && mul_avail, 1'b0, wb_dat_i[4:0]};
		end
		else if (!mul_avail)
			osc_trim_register_q[osc_ctrl_pkg::trim_mul_bit] <= 1'b0;

	always_comb
	begin
		rd_d = 32'h0000_0000;
		case (wb_adr_i)
			osc_ctrl_pkg::ctrl_addr: rd_d = {24'h000000, osc_control_register_q};
			osc_ctrl_pkg::trim_addr: rd_d = {24'h000000, osc_trim_register_q};
			osc_ctrl_pkg::feat_addr: rd_d = {24'h000000, feat_q};
			osc_ctrl_pkg::status_addr: rd_d = {24'h000000, 1'b0, multiplier_enable_eff, osc_cmd.src,
				osc_cmd.slow_osc_en, osc_cmd.fast_osc_en, slow_settling, fast_settling};
			default: rd_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			wb_dat_o <= 32'h0000_0000;
		else if (bus_req && !wb_we_i)
			wb_dat_o <= rd_d;

	// trim settle tracking; informational only, no flag to software beyond status
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			trim_prev_q <= 5'h00;
		else
			trim_prev_q <= osc_trim_register_q[4:0];

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			fast_cnt_q <= 15'h0000;
		else if (trim_prev_q != osc_trim_register_q[4:0])
			fast_cnt_q <= 15'(fast_settle_clks);
		else if (fast_cnt_q != 15'h0000)
			fast_cnt_q <= fast_cnt_q - 15'h0001;

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			slow_cnt_q <= 4'h0;
		else if (trim_prev_q != osc_trim_register_q[4:0])
			slow_cnt_q <= 4'(osc_ctrl_pkg::slow_settle_cycles);
		else if (slow_osc_tick && (slow_cnt_q != 4'h0))
			slow_cnt_q <= slow_cnt_q - 4'h1;

	assign fast_settling = fast_cnt_q != 15'h0000;
	assign slow_settling = slow_cnt_q != 4'h0;

	// oscillator command decode
	always_comb
	begin
		osc_cmd = '0;
		osc_cmd.trim = osc_trim_register_q[4:0];
		osc_cmd.start_delay_skip = mode_ext;
		osc_cmd.hs_mul_en = osc_mode_config == osc_ctrl_pkg::mode_hs_x4;
		osc_cmd.int_mul_en = multiplier_enable_eff;
		if (!mode_int)
			osc_cmd.src = osc_ctrl_pkg::src_primary;
		else if (internal_freq_select == osc_ctrl_pkg::freq_31k)
			osc_cmd.src = low_freq_source_select ? osc_ctrl_pkg::src_fast_div : osc_ctrl_pkg::src_slow;
		else
			osc_cmd.src = osc_ctrl_pkg::src_fast;
		osc_cmd.fast_div256 = mode_int && (internal_freq_select == osc_ctrl_pkg::freq_31k) && low_freq_source_select;
		osc_cmd.fast_osc_en = (mode_int && (internal_freq_select >= osc_ctrl_pkg::freq_125k)) ||
			osc_cmd.fast_div256;
		osc_cmd.slow_osc_en = (osc_cmd.src == osc_ctrl_pkg::src_slow) || (|feat_q[4:0]);
	end

	// divide-by-four clock output
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			div_q <= 2'h0;
		else
			div_q <= div_q + 2'h1;

	assign out_div4 = div_q[1];

	// pin muxing
	always_comb
	begin
		clock_out_pin_o = 1'b0;
		clock_out_pin_oe = 1'b0;
		clock_in_pin_o = 1'b0;
		clock_in_pin_oe = 1'b0;
		gpio_a_bit6_i = 1'b0;
		gpio_a_bit7_i = 1'b0;
		case (osc_mode_config)
			osc_ctrl_pkg::mode_ext_out, osc_ctrl_pkg::mode_rc_out:
			begin
				clock_out_pin_o = out_div4;
				clock_out_pin_oe = 1'b1;
			end
			osc_ctrl_pkg::mode_ext_io, osc_ctrl_pkg::mode_rc_io:
			begin
				clock_out_pin_o = gpio_a_bit6_o;
				clock_out_pin_oe = gpio_a_bit6_oe;
				gpio_a_bit6_i = clock_out_pin_i;
			end
			osc_ctrl_pkg::mode_int_clkout:
			begin
				clock_out_pin_o = out_div4;
				clock_out_pin_oe = 1'b1;
				clock_in_pin_o = gpio_a_bit7_o;
				clock_in_pin_oe = gpio_a_bit7_oe;
				gpio_a_bit7_i = clock_in_pin_i;
			end
			osc_ctrl_pkg::mode_int_two_io:
			begin
				clock_out_pin_o = gpio_a_bit6_o;
				clock_out_pin_oe = gpio_a_bit6_oe;
				gpio_a_bit6_i = clock_out_pin_i;
				clock_in_pin_o = gpio_a_bit7_o;
				clock_in_pin_oe = gpio_a_bit7_oe;
				gpio_a_bit7_i = clock_in_pin_i;
			end
			default:
			begin
				clock_out_pin_oe = 1'b0;
			end
		endcase
	end
endmodule

// ===== sim/osc_ctrl_monitor.sv
// checker: port-level relations of the oscillator control block
`timescale 1ns/100ps
module osc_ctrl_monitor #(
	parameter int fast_settle_clks = 20000
)(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [3:0] osc_mode_config,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic clock_in_pin_i,
	input wire logic clock_in_pin_oe,
	input wire logic clock_out_pin_i,
	input wire logic clock_out_pin_o,
	input wire logic clock_out_pin_oe,
	input wire logic gpio_a_bit6_oe,
	input wire logic gpio_a_bit6_i,
	input wire logic gpio_a_bit7_oe,
	input wire logic gpio_a_bit7_i,
	input wire osc_ctrl_pkg::osc_cmd_t osc_cmd
);
	wire logic [3:0] m = osc_mode_config;
	wire logic co_m = m == 4'h4 || m == 4'hc || m == 4'h9;
	wire logic io6_m = m == 4'h5 || m == 4'h7 || m == 4'h8;
	wire logic int_m = m == 4'h8 || m == 4'h9;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	AST_HS_MUL: assert property (osc_cmd.hs_mul_en == (m == 4'h6)) else $error("crystal x4 decode wrong");
	AST_INT_MUL: assert property (osc_cmd.int_mul_en |-> int_m) else $error("internal x4 in wrong mode");
	AST_SKIP: assert property (osc_cmd.start_delay_skip == (m == 4'h4 || m == 4'h5)) else $error("start delay");
	AST_CO_OE: assert property (co_m |-> clock_out_pin_oe) else $error("clock out pin not driven");
	AST_DIV4: assert property (co_m && $stable(m) && $rose(clock_out_pin_o) |=>
		(clock_out_pin_o || !co_m) ##1 (!clock_out_pin_o || !co_m)) else $error("div4 shape");
	AST_IO6: assert property (io6_m |-> clock_out_pin_oe == gpio_a_bit6_oe && gpio_a_bit6_i == clock_out_pin_i)
		else $error("second pin not io");
	AST_IO7: assert property (int_m |-> clock_in_pin_oe == gpio_a_bit7_oe && gpio_a_bit7_i == clock_in_pin_i)
		else $error("first pin not io");
	AST_DIV256: assert property (osc_cmd.src == osc_ctrl_pkg::src_fast_div |-> osc_cmd.fast_div256
		&& osc_cmd.fast_osc_en) else $error("div256 source");
	AST_SLOW: assert property (osc_cmd.src == osc_ctrl_pkg::src_slow |-> osc_cmd.slow_osc_en)
		else $error("slow oscillator off");
endmodule
bind osc_ctrl osc_ctrl_monitor #(.fast_settle_clks(fast_settle_clks)) u_mon (.sys_clk, .rst_n, .osc_mode_config,
	.wb_cyc_i, .wb_stb_i, .wb_ack_o, .clock_in_pin_i, .clock_in_pin_oe, .clock_out_pin_i, .clock_out_pin_o,
	.clock_out_pin_oe, .gpio_a_bit6_oe, .gpio_a_bit6_i, .gpio_a_bit7_oe, .gpio_a_bit7_i, .osc_cmd);

// ===== sim/osc_ctrl_test.sv
// testbench: registers, mode decode and pin muxing of the oscillator control block
`timescale 1ns/100ps
module osc_ctrl_test;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] mode = 4'h4;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, tick = 1'b0;
	logic [3:0] adr = 4'h0, sel = 4'h0;
	logic [31:0] dat = 32'h0, rdat, seed = 32'h22;
	logic e6 = 1'b0, e7 = 1'b0, g6o = 1'b0, g6e = 1'b0, g7o = 1'b0, g7e = 1'b0;
	logic ack, p6, p7, co_o, co_oe, ci_o, ci_oe, g6i, g7i;
	osc_ctrl_pkg::osc_cmd_t cmd;
	logic [31:0] expq[$];
	logic [3:0] modes [7] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hc};
	int err_count = 0, checks_done = 0, cyc_n = 0;
	assign p6 = co_oe ? co_o : e6;
	assign p7 = ci_oe ? ci_o : e7;
	osc_ctrl #(.fast_settle_clks(20)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .osc_mode_config(mode),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .slow_osc_tick(tick), .clock_in_pin_i(p7), .clock_in_pin_o(ci_o),
		.clock_in_pin_oe(ci_oe), .clock_out_pin_i(p6), .clock_out_pin_o(co_o), .clock_out_pin_oe(co_oe),
		.gpio_a_bit6_o(g6o), .gpio_a_bit6_oe(g6e), .gpio_a_bit6_i(g6i), .gpio_a_bit7_o(g7o),
		.gpio_a_bit7_oe(g7e), .gpio_a_bit7_i(g7i), .osc_cmd(cmd));
	initial forever #25 sys_clk = ~sys_clk;
	function automatic logic [31:0] xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge sys_clk)
	begin
		cyc_n <= cyc_n + 1;
		tick <= cyc_n % 8 == 0;
		if (ack === 1'b1 && we === 1'b0)
			chk(rdat, expq.pop_front());
		if (cyc_n == 6000)
		begin
			err_count++;
			tally_and_finish;
		end
	end
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		sel <= s;
		do @(posedge sys_clk); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		expq.push_back({24'h0, e});
		wb(1'b0, a, 8'h00, 4'hf);
	endtask
	initial
	begin
		logic [7:0] v;
		logic [3:0] m;
		logic im;
		logic [31:0] x;
		int hi;
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(4'h0, 8'h00);
		rd(4'h4, 8'h00);
		rd(4'h8, 8'h00);
		wb(1'b1, 4'h2, 8'hff, 4'hf);
		rd(4'h2, 8'h00);
		wb(1'b1, 4'h8, 8'h1f, 4'h0);
		rd(4'h8, 8'h00);
		for (int k = 0; k < 5; k++)
		begin
			wb(1'b1, 4'h8, 8'h01 << k, 4'h1);
			chk(cmd.slow_osc_en, 1'b1);
		end
		wb(1'b1, 4'h8, 8'h00, 4'h1);
		chk(cmd.slow_osc_en, 1'b0);
		foreach (modes[i])
		begin
			m = modes[i];
			im = m == 4'h8 || m == 4'h9;
			mode <= m;
			x = xorshift();
			v = x[7:0];
			wb(1'b1, 4'h4, v | 8'h60, 4'h1);
			rd(4'h4, (v & 8'h9f) | (im ? 8'h40 : 8'h00));
			chk(cmd.hs_mul_en, m == 4'h6);
			chk(cmd.start_delay_skip, m == 4'h4 || m == 4'h5);
			chk(cmd.trim, v[4:0]);
			for (int f = 0; f < 8; f++)
			begin
				wb(1'b1, 4'h0, {1'b0, f[2:0], 4'h0}, 4'h1);
				chk(cmd.int_mul_en, im && f > 5);
				if (im && f > 0)
					chk(cmd.fast_osc_en, 1'b1);
				if (im && f == 0)
					chk(cmd.src, v[7] ? osc_ctrl_pkg::src_fast_div : osc_ctrl_pkg::src_slow);
				if (im && f == 7)
					chk(cmd.src, osc_ctrl_pkg::src_fast);
			end
			x = xorshift();
			{e6, e7, g6o, g6e, g7o, g7e} <= x[5:0];
			repeat (2) @(posedge sys_clk);
			if (m == 4'h5 || m == 4'h7 || m == 4'h8)
				chk({co_oe, g6i}, {g6e, p6});
			if (im)
				chk({ci_oe, g7i}, {g7e, p7});
			if (m == 4'h4 || m == 4'hc || m == 4'h9)
			begin
				hi = 0;
				repeat (8)
				begin
					@(posedge sys_clk);
					hi += co_o;
				end
				chk({co_oe, 8'(hi)}, {1'b1, 8'h04});
			end
		end
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(4'h4, 8'h00);
		rd(4'hc, 8'h00);
		wb(1'b1, 4'h4, 8'h1f, 4'h1);
		rd(4'hc, 8'h03);
		repeat (80) @(posedge sys_clk);
		rd(4'hc, 8'h00);
		repeat (2) @(posedge sys_clk);
		tally_and_finish;
	end
endmodule
